// *** common/sipf_pkg.sv ***
// sipf_pkg: register map, field layout and shared types of the sensor
// idle-pin and interrupt-flag register bank.
// assumes a 32-bit plain register port with byte addresses.
package sipf_pkg;

	localparam int SIPF_ADDR_W = 8;
	localparam int SIPF_DATA_W = 32;
	localparam int SIPF_NUM_CH = 16;
	localparam int SIPF_NUM_ALT = 8;
	localparam int SIPF_NUM_DAC_CH = 4;
	localparam int SIPF_FLAG_W = 23;

	// register byte offsets
	localparam logic [7:0] SIPF_OFS_CH_IDLE = 8'h38;
	localparam logic [7:0] SIPF_OFS_ALT_CFG = 8'h3c;
	localparam logic [7:0] SIPF_OFS_FLAGS = 8'h40;
	localparam logic [7:0] SIPF_OFS_FLAG_CLR = 8'h44;
	localparam logic [7:0] SIPF_OFS_FLAG_SET = 8'h48;
	localparam logic [7:0] SIPF_OFS_FLAG_EN = 8'h4c;
	localparam logic [7:0] SIPF_OFS_PHASE = 8'h54;

	// field positions
	localparam int SIPF_ALT_IDLE_LSB = 0;
	localparam int SIPF_ALT_ALWAYS_LSB = 16;
	localparam int SIPF_FLAG_CH_LSB = 0;
	localparam int SIPF_FLAG_SWEEP = 16;
	localparam int SIPF_FLAG_DEC_REQ = 17;
	localparam int SIPF_FLAG_DEC_ERR = 18;
	localparam int SIPF_FLAG_VALID = 19;
	localparam int SIPF_FLAG_FULL = 20;
	localparam int SIPF_FLAG_RES_OF = 21;
	localparam int SIPF_FLAG_CNT_OF = 22;
	localparam int SIPF_PHASE_IDLE_BIT = 0;

	// reset values
	localparam logic [31:0] SIPF_RST_CH_IDLE = 32'h0000_0000;
	localparam logic [23:0] SIPF_RST_ALT_CFG = 24'h00_0000;
	localparam logic [22:0] SIPF_RST_FLAGS = 23'h00_0000;
	localparam logic [31:0] SIPF_RD_ZERO = 32'h0000_0000;

	// idle-phase drive codes
	typedef enum logic [1:0] {
		SIPF_IDLE_OFF = 2'b00,
		SIPF_IDLE_HIGH = 2'b01,
		SIPF_IDLE_LOW = 2'b10,
		SIPF_IDLE_CONV = 2'b11
	} sipf_idle_e;

	// hardware event pulses, one bit per flag position
	typedef struct packed {
		logic counter_overflow_flag;
		logic result_overflow_flag;
		logic result_full_flag;
		logic result_valid_flag;
		logic decoder_error_flag;
		logic decoder_request_flag;
		logic sweep_done_flag;
		logic [15:0] lane_trigger;
	} sipf_events_s;

	// one pin as two signals, out and oe
	typedef struct packed {
		logic [SIPF_NUM_CH-1:0] lane_out;
		logic [SIPF_NUM_CH-1:0] lane_oe;
		logic [SIPF_NUM_ALT-1:0] alt_out;
		logic [SIPF_NUM_ALT-1:0] alt_oe;
	} sipf_pins_s;

endpackage

// *** tb/sipf_sensor_model.sv ***
// sipf_sensor_model: sensors on lane and alt pins, seen as wire levels.
// assumes a weak pull-down on every pin.
`timescale 1ns/1ps
module sipf_sensor_model
	import sipf_pkg::*;
(
	input wire sipf_pins_s pins_i,
	output logic [SIPF_NUM_CH-1:0] lane_lvl_o,
	output logic [SIPF_NUM_ALT-1:0] alt_lvl_o
);
	// a released pin falls to the pull-down, never keeps its last value
	assign lane_lvl_o = pins_i.lane_out & pins_i.lane_oe;
	assign alt_lvl_o = pins_i.alt_out & pins_i.alt_oe;
endmodule

// *** tb/sipf_top_properties.sv ***
// sipf_top_properties: port-level checks of the register bank and flags.
// assumes one clock domain; bound onto sipf_top below.
`timescale 1ns/1ps
module sipf_top_properties
	import sipf_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [SIPF_ADDR_W-1:0] reg_addr_i,
	input wire logic [SIPF_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [SIPF_DATA_W-1:0] reg_rdata_o,
	input wire sipf_events_s events_i,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// write, quiet cycle, read; events held off so flags move only by the write
	sequence s_wr_rd(wa, ra);
		reg_write_i && reg_addr_i == wa && events_i == 0 ##1 !reg_write_i && events_i == 0
			##1 reg_read_i && reg_addr_i == ra;
	endsequence
	sequence s_ev_rd;
		events_i != 0 ##1 !reg_write_i ##1 reg_read_i && reg_addr_i == SIPF_OFS_FLAGS;
	endsequence
	property p_evt;
		s_ev_rd |=> (reg_rdata_o[22:0] & $past(events_i, 3)) == $past(events_i, 3);
	endproperty
	property p_clr;
		s_wr_rd(SIPF_OFS_FLAG_CLR, SIPF_OFS_FLAGS) |=> (reg_rdata_o & $past(reg_wdata_i, 3)) == 0;
	endproperty
	property p_set;
		s_wr_rd(SIPF_OFS_FLAG_SET, SIPF_OFS_FLAGS)
			|=> (reg_rdata_o & $past(reg_wdata_i, 3)) == $past(reg_wdata_i, 3);
	endproperty
	property p_lane;
		s_wr_rd(SIPF_OFS_CH_IDLE, SIPF_OFS_CH_IDLE) |=> reg_rdata_o == $past(reg_wdata_i, 3);
	endproperty
	// reserved write bits are dropped, so only 23:0 come back
	property p_alt;
		s_wr_rd(SIPF_OFS_ALT_CFG, SIPF_OFS_ALT_CFG)
			|=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h00ff_ffff);
	endproperty
	property p_irq_off;
		reg_write_i && reg_addr_i == SIPF_OFS_FLAG_EN && reg_wdata_i[22:0] == 0 |=> !irq_o;
	endproperty
	property p_clr_rd;
		reg_read_i && reg_addr_i == SIPF_OFS_FLAG_CLR |=> reg_rdata_o == 0;
	endproperty
	property p_flag_hi;
		reg_read_i && reg_addr_i == SIPF_OFS_FLAGS |=> reg_rdata_o[31:23] == 0;
	endproperty
	a_evt: assert property (p_evt) else $error("event flag missing");
	a_clr: assert property (p_clr) else $error("flag not cleared");
	a_set: assert property (p_set) else $error("flag not set");
	a_lane: assert property (p_lane) else $error("lane idle readback");
	a_alt: assert property (p_alt) else $error("alt cfg readback");
	a_irq_off: assert property (p_irq_off) else $error("irq while masked");
	a_clr_rd: assert property (p_clr_rd) else $error("clear reg not zero");
	a_flag_hi: assert property (p_flag_hi) else $error("flag upper bits");
endmodule

bind sipf_top sipf_top_properties chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
	.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .events_i(events_i), .irq_o(irq_o));

// *** tb/sipf_top_tb.sv ***
// sipf_top_tb: register, flag and idle pin scenarios for sipf_top.
// assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module sipf_top_tb;
	import sipf_pkg::*;
	logic ref_clk_i = 0, reset_i = 1, wr = 0, rd = 0, idle = 0, conv = 1;
	logic [7:0] addr = 8'h00, a_drv = 8'hff, alt_lvl;
	logic [31:0] wdata = 32'h0, rdata;
	logic [15:0] lane_lvl;
	sipf_events_s ev = '0;
	sipf_pins_s pins;
	logic irq;
	int bad_count = 0, total_checks = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	sipf_top dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
		.events_i(ev), .idle_phase_i(idle), .converter_out_first_i(conv),
		.lane_active_out_i(16'h0), .lane_active_oe_i(16'h0), .alt_active_out_i(a_drv),
		.alt_active_oe_i(a_drv), .pins_o(pins), .irq_o(irq));
	sipf_sensor_model sensor_u (.pins_i(pins), .lane_lvl_o(lane_lvl), .alt_lvl_o(alt_lvl));
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// bus cycles: one-cycle strobes, read data sampled in the following cycle
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	task pulse(input logic [22:0] v);
		@(posedge ref_clk_i);
		ev <= v;
		@(posedge ref_clk_i);
		ev <= '0;
	endtask
	// reset values, readback, unmapped read
	task t_regs();
		rd_chk(SIPF_OFS_CH_IDLE, 32'h0);
		rd_chk(SIPF_OFS_ALT_CFG, 32'h0);
		rd_chk(SIPF_OFS_FLAGS, 32'h0);
		rd_chk(SIPF_OFS_FLAG_EN, 32'h0);
		wr_reg(SIPF_OFS_CH_IDLE, 32'ha5c3_3c5a);
		rd_chk(SIPF_OFS_CH_IDLE, 32'ha5c3_3c5a);
		wr_reg(SIPF_OFS_ALT_CFG, 32'h00ff_ffff);
		rd_chk(SIPF_OFS_ALT_CFG, 32'h00ff_ffff);
		rd_chk(8'h60, 32'h0);
	endtask
	// every event source alone: flag, irq, then clear
	task t_flags();
		wr_reg(SIPF_OFS_FLAG_EN, 32'h007f_ffff);
		for (int i = 0; i < 23; i++) begin
			pulse(23'h1 << i);
			rd_chk(SIPF_OFS_FLAGS, 32'h1 << i);
			check(32'(irq), 32'h1);
			wr_reg(SIPF_OFS_FLAG_CLR, 32'h1 << i);
			rd_chk(SIPF_OFS_FLAGS, 32'h0);
		end
	endtask
	// zero writes and read-only writes must not disturb a set flag
	task t_sticky();
		pulse(23'h20);
		wr_reg(SIPF_OFS_FLAG_CLR, 32'h0);
		wr_reg(SIPF_OFS_FLAGS, 32'h0);
		rd_chk(SIPF_OFS_FLAGS, 32'h20);
		wr_reg(SIPF_OFS_FLAG_SET, 32'h0040_0001);
		rd_chk(SIPF_OFS_FLAGS, 32'h0040_0021);
		rd_chk(SIPF_OFS_FLAG_CLR, 32'h0);
		wr_reg(SIPF_OFS_FLAG_EN, 32'h0000_0002);
		#1 check(32'(irq), 32'h0);
		wr_reg(SIPF_OFS_FLAG_EN, 32'h0);
		wr_reg(SIPF_OFS_FLAG_CLR, 32'h007f_ffff);
	endtask
	// lanes 0-4 codes 3,1,2,0,3; alt pins 0,1 and pin 7 always driven
	task t_pins();
		wr_reg(SIPF_OFS_CH_IDLE, 32'h0000_0327);
		wr_reg(SIPF_OFS_ALT_CFG, 32'h0080_0009);
		idle <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1 check(32'({pins.lane_oe[4:0], lane_lvl[4:0]}), 32'h0e3);
		check(32'({pins.alt_oe, alt_lvl}), 32'h8381);
		conv <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1 check(32'(lane_lvl[1:0]), 32'h2);
		rd_chk(SIPF_OFS_PHASE, 32'h1);
		idle <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1 check(32'({pins.lane_oe, pins.alt_oe}), 32'h00ff);
	endtask
	// event and clear of the same flag in one cycle: the event must win
	task t_race();
		wr_reg(SIPF_OFS_FLAG_SET, 32'h0000_0001);
		@(posedge ref_clk_i);
		wr <= 1'b1;
		addr <= SIPF_OFS_FLAG_CLR;
		wdata <= 32'h0000_0003;
		ev <= 23'h00_0001;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		ev <= '0;
		rd_chk(SIPF_OFS_FLAGS, 32'h1);
		wr_reg(SIPF_OFS_FLAG_CLR, 32'h007f_ffff);
	endtask
	// reset in mid-run with a pending enabled flag: all back to zero
	task t_reset();
		wr_reg(SIPF_OFS_FLAG_EN, 32'h0000_0001);
		wr_reg(SIPF_OFS_FLAG_SET, 32'h0000_0001);
		#1 check(32'(irq), 32'h1);
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1 check(32'(irq), 32'h0);
		reset_i <= 1'b0;
		rd_chk(SIPF_OFS_FLAGS, 32'h0);
		rd_chk(SIPF_OFS_CH_IDLE, 32'h0);
		rd_chk(SIPF_OFS_FLAG_EN, 32'h0);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_flags();
		t_sticky();
		t_pins();
		t_race();
		t_reset();
		results();
	end
endmodule

// *** verilog/sipf_pin_drive.sv ***
// sipf_pin_drive: decodes one two-bit idle setting into a pin drive.
// assumes the caller registers the result before it leaves the block.
`timescale 1ns/1ps
module sipf_pin_drive
	import sipf_pkg::*;
#(
	parameter bit CONV_ALLOWED = 1'b0
) (
	input wire logic [1:0] setting_i,
	input wire logic idle_i,
	input wire logic active_out_i,
	input wire logic active_oe_i,
	input wire logic conv_i,
	output logic out_o,
	output logic oe_o
);
	// outside idle the sequencer owns the pin; code 3 only routes on lanes 0..3
	always_comb begin
		out_o = active_out_i;
		oe_o = active_oe_i;
		if (idle_i) begin
			case (sipf_idle_e'(setting_i))
				SIPF_IDLE_OFF: begin
					out_o = 1'b0;
					oe_o = 1'b0;
				end
				SIPF_IDLE_HIGH: begin
					out_o = 1'b1;
					oe_o = 1'b1;
				end
				SIPF_IDLE_LOW: begin
					out_o = 1'b0;
					oe_o = 1'b1;
				end
				SIPF_IDLE_CONV: begin
					out_o = CONV_ALLOWED ? conv_i : 1'b0;
					oe_o = CONV_ALLOWED;
				end
				default: begin
					out_o = 1'b0;
					oe_o = 1'b0;
				end
			endcase
		end
	end
endmodule

// *** verilog/sipf_top.sv ***
// sipf_top: idle-phase pin drive configuration and interrupt flag bank
// of a low-energy sensor interface.
// assumes a same-clock register master and same-clock event pulses;
// the idle phase level and the converter output come from pins.
`timescale 1ns/1ps
module sipf_top
	import sipf_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [SIPF_ADDR_W-1:0] reg_addr_i,
	input wire logic [SIPF_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [SIPF_DATA_W-1:0] reg_rdata_o,
	input wire sipf_events_s events_i,
	input wire logic idle_phase_i,
	input wire logic converter_out_first_i,
	input wire logic [SIPF_NUM_CH-1:0] lane_active_out_i,
	input wire logic [SIPF_NUM_CH-1:0] lane_active_oe_i,
	input wire logic [SIPF_NUM_ALT-1:0] alt_active_out_i,
	input wire logic [SIPF_NUM_ALT-1:0] alt_active_oe_i,
	output sipf_pins_s pins_o,
	output logic irq_o
);

	// whole module state
	typedef struct packed {
		logic [31:0] ch_idle;
		logic [23:0] alt_cfg;
		logic [SIPF_FLAG_W-1:0] flags;
		logic [SIPF_FLAG_W-1:0] flag_en;
		logic [SIPF_DATA_W-1:0] rdata;
		logic irq;
		logic idle_meta;
		logic idle_sync;
		logic conv_meta;
		logic conv_sync;
		sipf_pins_s pins;
	} sipf_state_s;

	sipf_state_s state;
	sipf_state_s next_state;
	logic [SIPF_NUM_CH-1:0] lane_out;
	logic [SIPF_NUM_CH-1:0] lane_oe;
	logic [SIPF_NUM_ALT-1:0] alt_out;
	logic [SIPF_NUM_ALT-1:0] alt_oe;
	logic [SIPF_FLAG_W-1:0] event_vec;

	// write decode shared by all writable registers
	function automatic logic is_write(input logic we, input logic [7:0] a,
		input logic [7:0] ofs);
		is_write = we && (a == ofs);
	endfunction

	// two-bit setting n of a packed field vector
	function automatic logic [1:0] field2(input logic [31:0] v, input int n);
		field2 = v[2*n +: 2];
	endfunction

	// events packed to the flag layout
	assign event_vec = events_i;

	// lane drive decode; only the first four may route the converter
	genvar g;
	generate
		for (g = 0; g < SIPF_NUM_CH; g++) begin : g_lane
			sipf_pin_drive #(
				.CONV_ALLOWED(g < SIPF_NUM_DAC_CH)
			) u_lane (
				.setting_i(field2(state.ch_idle, g)),
				.idle_i(state.idle_sync),
				.active_out_i(lane_active_out_i[g]),
				.active_oe_i(lane_active_oe_i[g]),
				.conv_i(state.conv_sync),
				.out_o(lane_out[g]),
				.oe_o(lane_oe[g])
			);
		end
		// always-drive keeps the active-phase drive through idle
		for (g = 0; g < SIPF_NUM_ALT; g++) begin : g_alt
			sipf_pin_drive #(
				.CONV_ALLOWED(1'b0)
			) u_alt (
				.setting_i(field2({8'h00, state.alt_cfg}, SIPF_ALT_IDLE_LSB / 2 + g)),
				.idle_i(state.idle_sync && !state.alt_cfg[SIPF_ALT_ALWAYS_LSB + g]),
				.active_out_i(alt_active_out_i[g]),
				.active_oe_i(alt_active_oe_i[g]),
				.conv_i(1'b0),
				.out_o(alt_out[g]),
				.oe_o(alt_oe[g])
			);
		end
	endgenerate

	// next state
	always_comb begin
		next_state = state;
		// pin-side levels pass two flops before use
		next_state.idle_meta = idle_phase_i;
		next_state.idle_sync = state.idle_meta;
		next_state.conv_meta = converter_out_first_i;
		next_state.conv_sync = state.conv_meta;

		// configuration writes; reserved upper bits are dropped
		if (is_write(reg_write_i, reg_addr_i, SIPF_OFS_CH_IDLE)) begin
			next_state.ch_idle = reg_wdata_i;
		end
		if (is_write(reg_write_i, reg_addr_i, SIPF_OFS_ALT_CFG)) begin
			next_state.alt_cfg = reg_wdata_i[23:0];
		end
		if (is_write(reg_write_i, reg_addr_i, SIPF_OFS_FLAG_EN)) begin
			next_state.flag_en = reg_wdata_i[SIPF_FLAG_W-1:0];
		end

		// clear first, then sets, so an event in the clear cycle survives
		if (is_write(reg_write_i, reg_addr_i, SIPF_OFS_FLAG_CLR)) begin
			next_state.flags = state.flags & ~reg_wdata_i[SIPF_FLAG_W-1:0];
		end
		if (is_write(reg_write_i, reg_addr_i, SIPF_OFS_FLAG_SET)) begin
			next_state.flags = next_state.flags | reg_wdata_i[SIPF_FLAG_W-1:0];
		end
		next_state.flags = next_state.flags | event_vec;

		// level interrupt registered together with the flags, from their next values
		next_state.irq = |(next_state.flags & next_state.flag_en);

		// read data valid only in the cycle after the strobe
		next_state.rdata = SIPF_RD_ZERO;
		if (reg_read_i) begin
			case (reg_addr_i)
				SIPF_OFS_CH_IDLE: next_state.rdata = state.ch_idle;
				SIPF_OFS_ALT_CFG: next_state.rdata = {8'h00, state.alt_cfg};
				SIPF_OFS_FLAGS: next_state.rdata = {9'h000, state.flags};
				SIPF_OFS_FLAG_EN: next_state.rdata = {9'h000, state.flag_en};
				SIPF_OFS_PHASE: next_state.rdata = {31'h0000_0000, state.idle_sync};
				default: next_state.rdata = SIPF_RD_ZERO; // clear/set read zero
			endcase
		end

		// pins registered so every output comes from a flop
		next_state.pins.lane_out = lane_out;
		next_state.pins.lane_oe = lane_oe;
		next_state.pins.alt_out = alt_out;
		next_state.pins.alt_oe = alt_oe;
	end

	// state register
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata_o = state.rdata;
	assign pins_o = state.pins;
	assign irq_o = state.irq;

endmodule
